// ==== design/baud_divider.sv ====
// baud-rate generator: one-cycle tick every divisor+1 clocks while running
// assumes divisor is stable software state on the same clock

`timescale 1ns/10ps

module baud_divider
  import sync_serial_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             next_tick;

  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (!run)
    begin
      next_count = '0;
    end
    else if (count >= divisor)
    begin
      next_count = '0;
      next_tick  = 1'b1;
    end
    else
    begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule : baud_divider

// ==== design/sync_serial_pkg.sv ====
// package for the synchronous serial port: register indices, fields, resets, timing
// assumes a 250 MHz APB clock and one aligned 32-bit word per register index

package sync_serial_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W                 = 20;
  localparam logic [15:0] IDX_TRANSMIT_HOLDING   = 16'hf480;
  localparam logic [15:0] IDX_RECEIVE_HOLDING    = 16'hf482;
  localparam logic [15:0] IDX_BAUD_DIVISOR       = 16'hf484;
  localparam logic [15:0] IDX_PRIMARY_CONTROL    = 16'hf486;
  localparam logic [15:0] IDX_CLOCK_ROLE_CONTROL = 16'hf488;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_RX_MASTER     = 0;
  localparam int unsigned BIT_TX_MASTER     = 1;
  localparam int unsigned BIT_RX_ENABLE     = 0;
  localparam int unsigned BIT_RX_IRQ_ENABLE = 1;
  localparam int unsigned BIT_RX_FULL       = 2;
  localparam int unsigned BIT_RX_OVERFLOW   = 3;
  localparam int unsigned BIT_TX_ENABLE     = 4;
  localparam int unsigned BIT_TX_IRQ_ENABLE = 5;
  localparam int unsigned BIT_TX_EMPTY      = 6;
  localparam int unsigned BIT_TX_UNDERFLOW  = 7;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned DIV_W           = 8;
  localparam logic [15:0] HOLDING_RESET   = 16'h0000;
  localparam logic [1:0]  ROLE_RESET      = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RESET  = 8'h00;
  localparam logic [3:0]  LAST_BIT        = 4'hf;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_KHZ            = 250000;
  localparam longint unsigned SLAVE_CLK_MAX_KHZ  = 6250;
  localparam int unsigned     SLAVE_MIN_PERIOD_CYCLES =
    int'((CLK_KHZ + SLAVE_CLK_MAX_KHZ - 1) / SLAVE_CLK_MAX_KHZ);

  typedef enum logic [0:0]
  {
    tx_idle     = 1'b0,
    tx_shifting = 1'b1
  } tx_state_t;

endpackage : sync_serial_pkg

// ==== design/sync_serial_port.sv ====
// synchronous serial port: clock roles, transmit and receive holding buffers, APB slave
// assumes bit clock pins arrive asynchronously; DMA and interrupt units sit outside
//
// Decided for this implementation: register access over APB.

`timescale 1ns/10ps

// Functional notes
// - control bit 1 makes transmitter clock master
// - slave transmit shifts on incoming pin clock
// - control bit 0 makes receiver clock master
// - master receive uses baud clock, drives pin
// - slave receive samples on external pin clock
// - written holding word loads into shifter
// - first received bit lands in msb
// - full received word copies to holding buffer
// - receive holding read returns latest word
// - transmit empty visible and sent to units
// - receive full visible and sent to units
// - external transmit clock up to 6.25 MHz
// - underflow cleared by zero, one ignored
// - holding write clears empty; load sets it
// - transmit irq enable gates empty signal
module sync_serial_port
  import sync_serial_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              tx_bit_clock_pin_in,
  output logic                   tx_bit_clock_pin_out,
  output logic                   tx_bit_clock_pin_oe,
  input  wire logic              rx_bit_clock_pin_in,
  output logic                   rx_bit_clock_pin_out,
  output logic                   rx_bit_clock_pin_oe,
  output logic                   tx_data_out,
  input  wire logic              rx_data_in,
  output logic                   tx_empty_request,
  output logic                   rx_full_request
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] tx_clk_sync;
  logic [2:0] rx_clk_sync;
  logic [1:0] rx_data_sync;

  // a 6.25 MHz slave clock gives about 20 clocks per level, ample for two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_clk_sync  <= '0;
      rx_clk_sync  <= '0;
      rx_data_sync <= '0;
    end
    else
    begin
      tx_clk_sync  <= {tx_clk_sync[1:0], tx_bit_clock_pin_in};
      rx_clk_sync  <= {rx_clk_sync[1:0], rx_bit_clock_pin_in};
      rx_data_sync <= {rx_data_sync[0], rx_data_in};
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [15:0] idx;
  logic        addr_ok;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;

  assign idx     = paddr[17:2];
  assign addr_ok = (paddr[ADDR_W-1:18] == '0) && (paddr[1:0] == 2'b00) &&
                   ((idx == IDX_TRANSMIT_HOLDING) || (idx == IDX_RECEIVE_HOLDING) ||
                    (idx == IDX_BAUD_DIVISOR) || (idx == IDX_PRIMARY_CONTROL) ||
                    (idx == IDX_CLOCK_ROLE_CONTROL));
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign wr      = access && pwrite && addr_ok;
  assign rd      = access && !pwrite && addr_ok;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [1:0]       role;
  logic [DIV_W-1:0] divisor;
  logic             tx_enable;
  logic             tx_irq_enable;
  logic             rx_enable;
  logic             rx_irq_enable;
  logic [1:0]       next_role;
  logic [DIV_W-1:0] next_divisor;
  logic             next_tx_enable;
  logic             next_tx_irq_enable;
  logic             next_rx_enable;
  logic             next_rx_irq_enable;

  always_comb
  begin
    next_role          = role;
    next_divisor       = divisor;
    next_tx_enable     = tx_enable;
    next_tx_irq_enable = tx_irq_enable;
    next_rx_enable     = rx_enable;
    next_rx_irq_enable = rx_irq_enable;
    if (wr && idx == IDX_CLOCK_ROLE_CONTROL)
    begin
      // upper bits are not stored, so software writing them back is harmless
      next_role = pwdata[1:0];
    end
    if (wr && idx == IDX_BAUD_DIVISOR)
    begin
      next_divisor = pwdata[DIV_W-1:0];
    end
    if (wr && idx == IDX_PRIMARY_CONTROL)
    begin
      next_tx_enable     = pwdata[BIT_TX_ENABLE];
      next_tx_irq_enable = pwdata[BIT_TX_IRQ_ENABLE];
      next_rx_enable     = pwdata[BIT_RX_ENABLE];
      next_rx_irq_enable = pwdata[BIT_RX_IRQ_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      role          <= ROLE_RESET;
      divisor       <= DIV_RESET;
      tx_enable     <= 1'b0;
      tx_irq_enable <= 1'b0;
      rx_enable     <= 1'b0;
      rx_irq_enable <= 1'b0;
    end
    else
    begin
      role          <= next_role;
      divisor       <= next_divisor;
      tx_enable     <= next_tx_enable;
      tx_irq_enable <= next_tx_irq_enable;
      rx_enable     <= next_rx_enable;
      rx_irq_enable <= next_rx_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // master bit clock
  // ---------------------------------------------------------------
  logic baud_tick;
  logic master_clk;
  logic next_master_clk;
  logic tx_master;
  logic rx_master;

  assign tx_master = role[BIT_TX_MASTER];
  assign rx_master = role[BIT_RX_MASTER];

  baud_divider u_baud
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (tx_master || rx_master),
    .divisor (divisor),
    .tick    (baud_tick)
  );

  always_comb
  begin
    next_master_clk = master_clk;
    if (!(tx_master || rx_master))
    begin
      next_master_clk = 1'b0;
    end
    else if (baud_tick)
    begin
      next_master_clk = !master_clk;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_clk           <= 1'b0;
      tx_bit_clock_pin_out <= 1'b0;
      tx_bit_clock_pin_oe  <= 1'b0;
      rx_bit_clock_pin_out <= 1'b0;
      rx_bit_clock_pin_oe  <= 1'b0;
    end
    else
    begin
      master_clk           <= next_master_clk;
      tx_bit_clock_pin_out <= next_master_clk && tx_master;
      tx_bit_clock_pin_oe  <= tx_master;
      rx_bit_clock_pin_out <= next_master_clk && rx_master;
      rx_bit_clock_pin_oe  <= rx_master;
    end
  end

  // transmit shifts on falling bit-clock edges, receive samples on rising ones
  logic tx_fall;
  logic rx_rise;

  assign tx_fall = tx_master ? (baud_tick && master_clk)
                             : (tx_clk_sync[2] && !tx_clk_sync[1]);
  assign rx_rise = rx_master ? (baud_tick && !master_clk)
                             : (!rx_clk_sync[2] && rx_clk_sync[1]);

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  tx_state_t          tx_state;
  tx_state_t          next_tx_state;
  logic [WORD_W-1:0]  tx_holding;
  logic [WORD_W-1:0]  tx_shift;
  logic [3:0]         tx_count;
  logic               tx_empty;
  logic               tx_underflow;
  logic [WORD_W-1:0]  next_tx_holding;
  logic [WORD_W-1:0]  next_tx_shift;
  logic [3:0]         next_tx_count;
  logic               next_tx_empty;
  logic               next_tx_underflow;
  logic               holding_write;

  assign holding_write = wr && idx == IDX_TRANSMIT_HOLDING;

  always_comb
  begin
    next_tx_state     = tx_state;
    next_tx_holding   = tx_holding;
    next_tx_shift     = tx_shift;
    next_tx_count     = tx_count;
    next_tx_empty     = tx_empty;
    next_tx_underflow = tx_underflow;
    if (wr && idx == IDX_PRIMARY_CONTROL && !pwdata[BIT_TX_UNDERFLOW])
    begin
      next_tx_underflow = 1'b0;
    end
    if (holding_write)
    begin
      next_tx_holding = pwdata[WORD_W-1:0];
      next_tx_empty   = 1'b0;
    end
    case (tx_state)
      tx_idle:
      begin
        if (tx_enable && tx_fall && !tx_empty)
        begin
          next_tx_shift = tx_holding;
          next_tx_count = '0;
          next_tx_empty = 1'b1;
          next_tx_state = tx_shifting;
        end
      end
      tx_shifting:
      begin
        if (!tx_enable)
        begin
          next_tx_state = tx_idle;
        end
        else if (tx_fall && tx_count == LAST_BIT)
        begin
          if (!tx_empty)
          begin
            next_tx_shift = tx_holding;
            next_tx_count = '0;
            next_tx_empty = 1'b1;
          end
          else
          begin
            // hardware set wins over a same-cycle software clear
            next_tx_underflow = 1'b1;
            next_tx_state     = tx_idle;
          end
        end
        else if (tx_fall)
        begin
          next_tx_shift = {tx_shift[WORD_W-2:0], 1'b0};
          next_tx_count = tx_count + 4'h1;
        end
      end
      default:
      begin
        next_tx_state = tx_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state     <= tx_idle;
      tx_holding   <= HOLDING_RESET;
      tx_shift     <= HOLDING_RESET;
      tx_count     <= '0;
      tx_empty     <= 1'b1;
      tx_underflow <= 1'b0;
      tx_data_out  <= 1'b0;
    end
    else
    begin
      tx_state     <= next_tx_state;
      tx_holding   <= next_tx_holding;
      tx_shift     <= next_tx_shift;
      tx_count     <= next_tx_count;
      tx_empty     <= next_tx_empty;
      tx_underflow <= next_tx_underflow;
      tx_data_out  <= (next_tx_state == tx_shifting) && next_tx_shift[WORD_W-1];
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rx_shift;
  logic [WORD_W-1:0] rx_holding;
  logic [3:0]        rx_count;
  logic              rx_full;
  logic              rx_overflow;
  logic [WORD_W-1:0] next_rx_shift;
  logic [WORD_W-1:0] next_rx_holding;
  logic [3:0]        next_rx_count;
  logic              next_rx_full;
  logic              next_rx_overflow;

  always_comb
  begin
    next_rx_shift    = rx_shift;
    next_rx_holding  = rx_holding;
    next_rx_count    = rx_count;
    next_rx_full     = rx_full;
    next_rx_overflow = rx_overflow;
    if (rd && idx == IDX_RECEIVE_HOLDING)
    begin
      next_rx_full = 1'b0;
    end
    if (wr && idx == IDX_PRIMARY_CONTROL && !pwdata[BIT_RX_OVERFLOW])
    begin
      next_rx_overflow = 1'b0;
    end
    if (!rx_enable)
    begin
      next_rx_count = '0;
    end
    else if (rx_rise)
    begin
      next_rx_shift = {rx_shift[WORD_W-2:0], rx_data_sync[1]};
      next_rx_count = rx_count + 4'h1;
      if (rx_count == LAST_BIT)
      begin
        next_rx_holding  = {rx_shift[WORD_W-2:0], rx_data_sync[1]};
        next_rx_full     = 1'b1;
        next_rx_overflow = rx_overflow || rx_full;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_shift    <= HOLDING_RESET;
      rx_holding  <= HOLDING_RESET;
      rx_count    <= '0;
      rx_full     <= 1'b0;
      rx_overflow <= 1'b0;
    end
    else
    begin
      rx_shift    <= next_rx_shift;
      rx_holding  <= next_rx_holding;
      rx_count    <= next_rx_count;
      rx_full     <= next_rx_full;
      rx_overflow <= next_rx_overflow;
    end
  end

  // ---------------------------------------------------------------
  // read data, answer and unit requests
  // ---------------------------------------------------------------
  logic [7:0]  status;
  logic [31:0] next_prdata;

  assign status = {tx_underflow, tx_empty, tx_irq_enable, tx_enable,
                   rx_overflow, rx_full, rx_irq_enable, rx_enable};

  always_comb
  begin
    next_prdata = prdata;
    if (setup && !pwrite)
    begin
      case (idx)
        IDX_RECEIVE_HOLDING:    next_prdata = {16'h0000, rx_holding};
        IDX_BAUD_DIVISOR:       next_prdata = {24'h000000, divisor};
        IDX_PRIMARY_CONTROL:    next_prdata = {24'h000000, status};
        IDX_CLOCK_ROLE_CONTROL: next_prdata = {30'h0, role};
        default:                next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata           <= 32'h00000000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      tx_empty_request <= 1'b0;
      rx_full_request  <= 1'b0;
    end
    else
    begin
      prdata           <= next_prdata;
      pready           <= setup;
      pslverr          <= setup && !addr_ok;
      tx_empty_request <= next_tx_empty && tx_irq_enable;
      rx_full_request  <= next_rx_full && rx_irq_enable;
    end
  end

endmodule : sync_serial_port

// ==== testbench/ext_serial_dev.sv ====
// model of the external serial device that clocks both directions as slave master
// assumes the bench resolves the clock pins and pulses each start for one cycle

`timescale 1ns/10ps

module ext_serial_dev
#(
  parameter int HALF = 24
)
(
  input  wire logic        pclk,
  input  wire logic        rx_start,
  input  wire logic [15:0] rx_word,
  input  wire logic        tx_start,
  input  wire logic        tx_clk_wire,
  input  wire logic        tx_data,
  output logic             rx_clk_drive,
  output logic             tx_clk_drive,
  output logic             rx_data,
  output logic             busy,
  output logic [31:0]      tx_seen
);
  initial
  begin
    rx_clk_drive = 1'b0;
    tx_clk_drive = 1'b0;
    rx_data      = 1'b0;
    busy         = 1'b0;
    tx_seen      = 32'h0;
  end

  // ----
  // frames: clocks stand low between them, half period of HALF pclk cycles
  // ----
  always @(posedge pclk)
  begin
    if (rx_start)
    begin
      busy <= 1'b1;
      for (int i = 15; i >= 0; i--)
      begin
        rx_data <= rx_word[i];
        repeat (HALF) @(posedge pclk);
        rx_clk_drive <= 1'b1;
        repeat (HALF) @(posedge pclk);
        rx_clk_drive <= 1'b0;
      end
      repeat (HALF) @(posedge pclk);
      rx_data <= ~rx_data;
      busy    <= 1'b0;
    end
    else if (tx_start)
    begin
      busy <= 1'b1;
      // one extra period: the first fall only loads the shifter
      repeat (33)
      begin
        tx_clk_drive <= 1'b1;
        repeat (HALF) @(posedge pclk);
        tx_clk_drive <= 1'b0;
        repeat (HALF) @(posedge pclk);
      end
      busy <= 1'b0;
    end
  end

  always @(posedge tx_clk_wire)
    tx_seen <= {tx_seen[30:0], tx_data};
endmodule : ext_serial_dev

// ==== testbench/sync_serial_props.sv ====
// checker for the synchronous serial port, watching its top-level ports only
// assumes it is bound to sync_serial_port from the bench top file

`timescale 1ns/10ps

module sync_serial_props
  import sync_serial_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_bit_clock_pin_out,
  input wire logic              tx_bit_clock_pin_oe,
  input wire logic              rx_bit_clock_pin_out,
  input wire logic              rx_bit_clock_pin_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----
  // sequences and properties
  // ----
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_role_wr;
    psel && penable && pready && pwrite && paddr == 20'h3d220;
  endsequence

  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_unmapped_err;
    psel && !penable && !(paddr inside {20'h3d200, 20'h3d208, 20'h3d210, 20'h3d218,
      20'h3d220}) |=> pslverr && pready;
  endproperty
  // role flop then pin flop, so allow two edges
  property p_tx_oe;
    s_role_wr |-> ##2 tx_bit_clock_pin_oe == $past(pwdata[1], 2);
  endproperty
  property p_rx_oe;
    s_role_wr |-> ##2 rx_bit_clock_pin_oe == $past(pwdata[0], 2);
  endproperty
  property p_tx_out_quiet;
    !tx_bit_clock_pin_oe && $past(!tx_bit_clock_pin_oe) |-> !tx_bit_clock_pin_out;
  endproperty
  property p_rx_out_quiet;
    !rx_bit_clock_pin_oe && $past(!rx_bit_clock_pin_oe) |-> !rx_bit_clock_pin_out;
  endproperty
  property p_tx_rd_zero;
    s_setup ##0 (!pwrite && paddr == 20'h3d200) |=> prdata == 32'h0;
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  a_unmapped_err: assert property (p_unmapped_err) else $error("no pslverr");
  a_tx_oe: assert property (p_tx_oe) else $error("tx pin enable wrong");
  a_rx_oe: assert property (p_rx_oe) else $error("rx pin enable wrong");
  a_tx_out_quiet: assert property (p_tx_out_quiet) else $error("tx clock out");
  a_rx_out_quiet: assert property (p_rx_out_quiet) else $error("rx clock out");
  a_tx_rd_zero: assert property (p_tx_rd_zero) else $error("tx holding read");
endmodule : sync_serial_props

// ==== testbench/tb.sv ====
// self-checking bench for the synchronous serial port
// assumes the checker and the external device model are compiled before it

`timescale 1ns/10ps

`define CHK(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb
  import sync_serial_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, tx_seen;
  logic              tx_bit_clock_pin_out, tx_bit_clock_pin_oe, tx_clk_wire, tx_data_out;
  logic              rx_bit_clock_pin_out, rx_bit_clock_pin_oe, rx_clk_wire, rx_data_in;
  logic              tx_empty_request, rx_full_request, err, rx_start, tx_start;
  logic              rx_clk_drive, tx_clk_drive, dev_busy;
  logic [15:0]       rx_word;
  int                num_errors, n_tests, cycles;

  assign tx_clk_wire = tx_bit_clock_pin_oe ? tx_bit_clock_pin_out : tx_clk_drive;
  assign rx_clk_wire = rx_bit_clock_pin_oe ? rx_bit_clock_pin_out : rx_clk_drive;

  sync_serial_port uut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_bit_clock_pin_in(tx_clk_wire), .tx_bit_clock_pin_out,
    .tx_bit_clock_pin_oe, .rx_bit_clock_pin_in(rx_clk_wire), .rx_bit_clock_pin_out,
    .rx_bit_clock_pin_oe, .tx_data_out, .rx_data_in, .tx_empty_request, .rx_full_request
  );

  ext_serial_dev dev
  (
    .pclk, .rx_start, .rx_word, .tx_start, .tx_clk_wire, .tx_data(tx_data_out),
    .rx_clk_drive, .tx_clk_drive, .rx_data(rx_data_in), .busy(dev_busy), .tx_seen
  );

  always #2 pclk = ~pclk;

  // ----
  // bus and closing tasks
  // ----
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [19:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0);
    `CHK(w, e, rd)
  endtask : rchk

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rchk(20'h3d220, 32'h0, "role reset");
    rchk(20'h3d208, 32'h0, "rx holding reset");
    rchk(20'h3d218, 32'h40, "status reset");
    rchk(20'h3d200, 32'h0, "tx holding read");
    rchk(20'h3d224, 32'h0, "unmapped read");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 20'h3d220, 32'h3);
    rchk(20'h3d220, 32'h3, "role bits");
    `CHK("tx oe", 1'b1, tx_bit_clock_pin_oe)
    `CHK("rx oe", 1'b1, rx_bit_clock_pin_oe)
    apb(1'b1, 20'h3d220, 32'h0);
  endtask : t_regs

  task automatic t_tx;
    apb(1'b1, 20'h3d218, 32'h30);
    repeat (2) @(posedge pclk);
    `CHK("empty request", 1'b1, tx_empty_request)
    apb(1'b1, 20'h3d200, 32'ha5c3);
    repeat (2) @(posedge pclk);
    `CHK("empty after write", 1'b0, tx_empty_request)
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    while (tx_empty_request !== 1'b1)
      @(posedge pclk);
    apb(1'b1, 20'h3d200, 32'h3c5a);
    while (dev_busy)
      @(posedge pclk);
    `CHK("tx words", 32'ha5c33c5a, tx_seen)
    rchk(20'h3d218, 32'hf0, "underflow set");
    apb(1'b1, 20'h3d218, 32'h90);
    rchk(20'h3d218, 32'hd0, "underflow kept");
    `CHK("request masked", 1'b0, tx_empty_request)
    apb(1'b1, 20'h3d218, 32'h10);
    rchk(20'h3d218, 32'h50, "underflow cleared");
  endtask : t_tx

  task automatic t_rx;
    apb(1'b1, 20'h3d218, 32'h3);
    rx_word  <= 16'h9b61;
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    @(posedge pclk);
    while (dev_busy)
      @(posedge pclk);
    `CHK("full request", 1'b1, rx_full_request)
    rchk(20'h3d208, 32'h9b61, "rx word");
    repeat (2) @(posedge pclk);
    `CHK("full cleared", 1'b0, rx_full_request)
  endtask : t_rx

  // divisor 3 gives a bit period of 8 cycles, so 4 rising edges in 32
  task automatic t_master;
    logic pt, pr;
    int   nt, nr;
    apb(1'b1, 20'h3d210, 32'h3);
    apb(1'b1, 20'h3d220, 32'h3);
    repeat (8) @(posedge pclk);
    pt = tx_bit_clock_pin_out;
    pr = rx_bit_clock_pin_out;
    nt = 0;
    nr = 0;
    repeat (32)
    begin
      @(posedge pclk);
      nt += int'(tx_bit_clock_pin_out && !pt);
      nr += int'(rx_bit_clock_pin_out && !pr);
      pt = tx_bit_clock_pin_out;
      pr = rx_bit_clock_pin_out;
    end
    `CHK("tx master clock", 4, nt)
    `CHK("rx master clock", 4, nr)
    // holding is written before the enable so the empty request cannot be stale
    apb(1'b1, 20'h3d200, 32'h96e1);
    apb(1'b1, 20'h3d218, 32'h30);
    while (tx_empty_request !== 1'b1)
      @(posedge pclk);
    pt = tx_bit_clock_pin_out;
    nt = 0;
    while (nt < 16)
    begin
      @(posedge pclk);
      nt += int'(tx_bit_clock_pin_out && !pt);
      pt = tx_bit_clock_pin_out;
    end
    `CHK("tx master word", 16'h96e1, tx_seen[15:0])
  endtask : t_master

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict;
    end
  end

  initial
  begin
    pclk     = 1'b0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 20'h0;
    pwdata   = 32'h0;
    rx_start = 1'b0;
    tx_start = 1'b0;
    rx_word  = 16'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_master;
    give_verdict;
  end
endmodule : tb

bind sync_serial_port sync_serial_props chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .tx_bit_clock_pin_out, .tx_bit_clock_pin_oe, .rx_bit_clock_pin_out, .rx_bit_clock_pin_oe
);
